/* src/lpbs_consts.svh */
// timing counts and command codes for the power and bank state logic
// assumes a 200 MHz system clock, one rising edge per command slot
`ifndef LPBS_CONSTS_SVH
`define LPBS_CONSTS_SVH
`define LPBS_CLK_MHZ        200
`define LPBS_TRCD_NS        18
`define LPBS_TRP_NS         18
`define LPBS_TRFCAB_NS      130
`define LPBS_TMRR_CYC       2
`define LPBS_TMRW_CYC       5
`define LPBS_TINIT5_NS      10000
`define LPBS_BURST_CYC      4
// cycles: least times round up
`define LPBS_CYC(ns) (((ns) * `LPBS_CLK_MHZ + 999) / 1000)
// command codes on ca[3:0] with chip select low (ca0 is bit 0)
`define LPBS_CA_MRW   4'h0
`define LPBS_CA_MRR   4'h8
`define LPBS_CA_REFPB 4'h4
`define LPBS_CA_REFAB 4'hC
`define LPBS_CA_WR    4'h1
`define LPBS_CA_RD    4'h5
`define LPBS_CA_PRE   4'hB
`define LPBS_CA_BST   4'h3
`define LPBS_CA_NOP   4'h7
// mode register address of the reset command
`define LPBS_MA_RESET 8'h3F
`define LPBS_AP_BIT   0
`define LPBS_AB_BIT   4
`endif

/* src/lpbs_pkg.sv */
// types shared by the power and bank state logic
// no assumptions beyond a SystemVerilog compiler
`default_nettype none
package lpbs_pkg;
    typedef enum logic [2:0] {
        BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READING, BK_WRITING,
        BK_PRECHARGING
    } lpbs_bank_t;
    typedef enum logic [3:0] {
        DV_POWER_ON, DV_RESETTING, DV_NORMAL, DV_ACT_PD, DV_IDLE_PD,
        DV_RST_PD, DV_SELF_REF, DV_DEEP_PD, DV_REFRESH, DV_MR_READ,
        DV_MR_WRITE
    } lpbs_dev_t;
endpackage : lpbs_pkg
`default_nettype wire

/* src/lpbs_bank.sv */
// one bank's row state machine with its own timer
// assumes decoded single-cycle command strobes from the top module
`default_nettype none
`include "lpbs_consts.svh"
module lpbs_bank
    import lpbs_pkg::*;
#(
    parameter int TRCD = `LPBS_CYC(`LPBS_TRCD_NS),
    parameter int TRP  = `LPBS_CYC(`LPBS_TRP_NS),
    parameter int BURST = `LPBS_BURST_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       cmdAct,
    input  wire logic       cmdRd,
    input  wire logic       cmdWr,
    input  wire logic       cmdPre,
    input  wire logic       cmdBst,
    input  wire logic       cmdAp,
    input  wire logic       clearAll,
    output lpbs_bank_t      state,
    output logic            autoPre
);
    logic [7:0] timer_r, timer_nxt;
    lpbs_bank_t state_r, state_nxt;
    logic       ap_r, ap_nxt;

    assign state   = state_r;
    assign autoPre = ap_r;

    // next state for the bank
    always_comb begin
        state_nxt   = state_r;
        timer_nxt   = (timer_r != 8'h00) ? timer_r - 8'h01 : 8'h00;
        ap_nxt      = ap_r;
        case (state_r)
            BK_IDLE: begin
                if (cmdAct) begin
                    state_nxt = BK_ACTIVATING;
                    timer_nxt = 8'(TRCD - 1);
                end
            end
            BK_ACTIVATING: begin
                if (timer_r == 8'h00) state_nxt = BK_ACTIVE;
            end
            BK_READING, BK_WRITING: begin
                if (cmdBst) begin
                    state_nxt = BK_ACTIVE;
                    ap_nxt = 1'b0;
                end else if (timer_r == 8'h00) begin
                    // burst done: precharge if auto precharge set
                    if (ap_r) begin
                        state_nxt = BK_PRECHARGING;
                        timer_nxt = 8'(TRP - 1);
                        ap_nxt = 1'b0;
                    end else begin
                        state_nxt = BK_ACTIVE;
                    end
                end
            end
            BK_PRECHARGING: begin
                if (timer_r == 8'h00) state_nxt = BK_IDLE;
            end
            default: ;
        endcase
        // column commands from active or mid-burst start a new burst
        if ((cmdRd || cmdWr) && (state_r == BK_ACTIVE ||
            state_r == BK_READING || state_r == BK_WRITING)) begin
            state_nxt = cmdRd ? BK_READING : BK_WRITING;
            timer_nxt = 8'(BURST - 1);
            ap_nxt = cmdAp;
        end
        // precharge from any state, idle included, still takes tRP
        if (cmdPre) begin
            state_nxt = BK_PRECHARGING;
            timer_nxt = 8'(TRP - 1);
            ap_nxt = 1'b0;
        end
        if (clearAll) begin
            state_nxt = BK_IDLE;
            timer_nxt = 8'h00;
            ap_nxt = 1'b0;
        end
    end

    // register the bank state
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r   <= BK_IDLE;
            timer_r   <= 8'h00;
            ap_r      <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            timer_r   <= timer_nxt;
            ap_r      <= ap_nxt;
        end
    end
endmodule : lpbs_bank
`default_nettype wire

/* src/lpbs_state_logic.sv */
// power state and four-bank command state logic of a low-power DRAM
// assumes pins cs_n, cke, ca arrive from outside and are synchronised
`default_nettype none
`include "lpbs_consts.svh"
module lpbs_state_logic
    import lpbs_pkg::*;
#(
    parameter int NBANK  = 4,
    parameter int TRFCAB = `LPBS_CYC(`LPBS_TRFCAB_NS),
    parameter int TMRR   = `LPBS_TMRR_CYC,
    parameter int TMRW   = `LPBS_TMRW_CYC,
    parameter int TINIT5 = `LPBS_CYC(`LPBS_TINIT5_NS)
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       csPin_n,
    input  wire logic       ckePin,
    input  wire logic [9:0] caRise,
    input  wire logic [9:0] caFall,
    output lpbs_dev_t       devState,
    output logic [11:0]     bankStates,
    output logic            modeRegWe,
    output logic [7:0]      modeRegAddr,
    output logic [7:0]      modeRegData
);
    // two-stage synchronisers for the pins
    logic        csMeta_r, cs_n_r, ckeMeta_r, cke_r, ckePrev_r;
    logic [19:0] caMeta_r, ca_r;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            csMeta_r  <= 1'b1;
            cs_n_r    <= 1'b1;
            ckeMeta_r <= 1'b0;
            cke_r     <= 1'b0;
            caMeta_r  <= 20'h00000;
            ca_r      <= 20'h00000;
        end else begin
            csMeta_r  <= csPin_n;
            cs_n_r    <= csMeta_r;
            ckeMeta_r <= ckePin;
            cke_r     <= ckeMeta_r;
            caMeta_r  <= {caFall, caRise};
            ca_r      <= caMeta_r;
        end
    end

    // command decode: current and previous cke level both matter
    logic [3:0] op;
    logic       ckeHH, ckeHL, ckeLH, sel;
    logic       isMrw, isMrr, isRefAb, isAct, isRd, isWr, isPre, isBst;
    logic       isSref, isDpd, isReset;
    logic [1:0] ba;
    always_comb begin
        op      = ca_r[3:0];
        ckeHH   = ckePrev_r && cke_r;
        ckeHL   = ckePrev_r && !cke_r;
        ckeLH   = !ckePrev_r && cke_r;
        sel     = !cs_n_r;
        ba      = ca_r[8:7];
        isMrw   = ckeHH && sel && op == `LPBS_CA_MRW;
        isMrr   = ckeHH && sel && op == `LPBS_CA_MRR;
        isRefAb = ckeHH && sel && op == `LPBS_CA_REFAB;
        // per-bank refresh code decodes to nothing with cke held high; with cke falling it decodes as self refresh
        isAct   = ckeHH && sel && ca_r[1:0] == 2'h2;
        isWr    = ckeHH && sel && op[2:0] == 3'h1;
        isRd    = ckeHH && sel && op[2:0] == 3'h5;
        isPre   = ckeHH && sel && op == `LPBS_CA_PRE;
        isBst   = ckeHH && sel && op == `LPBS_CA_BST;
        isSref  = ckeHL && sel && op[2:0] == 3'h4;
        isDpd   = ckeHL && sel && op[2:0] == 3'h3;
        isReset = isMrw && ca_r[9:4] == 6'h3F && ca_r[11:10] == 2'h0;
    end

    // per-bank state machines
    lpbs_dev_t  devState_r, devState_nxt;
    lpbs_bank_t bankSt [NBANK];
    logic [NBANK-1:0] bankAp;
    logic [1:0] lastBank_r, lastBank_nxt;
    logic       clearAll;
    logic       anyBusy, allIdle;
    genvar g;
    generate
        for (g = 0; g < NBANK; g++) begin : gBank
            logic hit;
            assign hit = (ba == 2'(g));
            lpbs_bank u_bank (
                .clk_sys  (clk_sys),
                .reset_n  (reset_n),
                .cmdAct   (isAct && hit && devState_r == DV_NORMAL),
                .cmdRd    (isRd && hit && devState_r == DV_NORMAL),
                .cmdWr    (isWr && hit && devState_r == DV_NORMAL),
                .cmdPre   (isPre && devState_r == DV_NORMAL &&
                           (hit || ca_r[`LPBS_AB_BIT])),
                .cmdBst   (isBst && lastBank_r == 2'(g) &&
                           devState_r == DV_NORMAL),
                .cmdAp    (ca_r[10 + `LPBS_AP_BIT]),
                .clearAll (clearAll),
                .state    (bankSt[g]),
                .autoPre  (bankAp[g])
            );
        end
    endgenerate

    // summary of bank activity
    always_comb begin
        allIdle = 1'b1;
        anyBusy = 1'b0;
        for (int i = 0; i < NBANK; i++) begin
            if (bankSt[i] != BK_IDLE) allIdle = 1'b0;
            if (bankSt[i] != BK_IDLE) anyBusy = 1'b1;
        end
    end

    // device level state machine
    lpbs_dev_t   mrrRet_r, mrrRet_nxt;
    logic [15:0] devTimer_r, devTimer_nxt;
    logic [15:0] initTimer_r, initTimer_nxt;
    logic        mrWe_r, mrWe_nxt;
    logic [7:0]  mrAddr_r, mrAddr_nxt, mrData_r, mrData_nxt;
    always_comb begin
        devState_nxt  = devState_r;
        mrrRet_nxt    = mrrRet_r;
        devTimer_nxt  = (devTimer_r != 16'h0000) ?
                        devTimer_r - 16'h0001 : 16'h0000;
        initTimer_nxt = (initTimer_r != 16'h0000) ?
                        initTimer_r - 16'h0001 : 16'h0000;
        lastBank_nxt  = lastBank_r;
        clearAll      = 1'b0;
        mrWe_nxt      = 1'b0;
        mrAddr_nxt    = mrAddr_r;
        mrData_nxt    = mrData_r;
        if ((isRd || isWr) && devState_r == DV_NORMAL)
            lastBank_nxt = ba;
        case (devState_r)
            DV_POWER_ON: begin
                if (isReset) begin
                    devState_nxt  = DV_RESETTING;
                    initTimer_nxt = 16'(TINIT5);
                end
            end
            DV_RESETTING: begin
                if (ckeHL && cs_n_r) devState_nxt = DV_RST_PD;
                else if (isMrr) begin
                    devState_nxt = DV_MR_READ;
                    mrrRet_nxt   = DV_NORMAL;
                    devTimer_nxt = 16'(TMRR - 1);
                end else if (initTimer_r == 16'h0000)
                    devState_nxt = DV_NORMAL;
            end
            DV_NORMAL: begin
                if (ckeHL && cs_n_r)
                    devState_nxt = anyBusy ? DV_ACT_PD : DV_IDLE_PD;
                else if (isSref && allIdle)
                    devState_nxt = DV_SELF_REF;
                else if (isDpd && allIdle)
                    devState_nxt = DV_DEEP_PD;
                else if (isRefAb && allIdle) begin
                    devState_nxt = DV_REFRESH;
                    devTimer_nxt = 16'(TRFCAB - 1);
                end else if (isReset && allIdle) begin
                    devState_nxt  = DV_RESETTING;
                    initTimer_nxt = 16'(TINIT5);
                    clearAll      = 1'b1;
                end else if (isMrw && allIdle) begin
                    devState_nxt = DV_MR_WRITE;
                    devTimer_nxt = 16'(TMRW - 1);
                end else if (isMrr) begin
                    devState_nxt = DV_MR_READ;
                    mrrRet_nxt   = DV_NORMAL;
                    devTimer_nxt = 16'(TMRR - 1);
                end
            end
            DV_ACT_PD, DV_IDLE_PD, DV_SELF_REF: begin
                if (ckeLH && cs_n_r) devState_nxt = DV_NORMAL;
            end
            DV_RST_PD: begin
                if (ckeLH && cs_n_r)
                    devState_nxt = (initTimer_r == 16'h0000) ?
                                   DV_NORMAL : DV_RESETTING;
            end
            DV_DEEP_PD: begin
                if (ckeLH && cs_n_r) begin
                    devState_nxt = DV_POWER_ON;
                    clearAll     = 1'b1;
                end
            end
            DV_REFRESH, DV_MR_READ, DV_MR_WRITE: begin
                if (devTimer_r == 16'h0000)
                    devState_nxt = DV_NORMAL;
            end
            default: devState_nxt = DV_POWER_ON;
        endcase
        // every accepted mode write, reset included, loads its register
        if (isMrw && ((devState_r == DV_POWER_ON && isReset) ||
                      (devState_r == DV_NORMAL && allIdle))) begin
            mrWe_nxt   = 1'b1;
            mrAddr_nxt = {ca_r[11:10], ca_r[9:4]};
            mrData_nxt = ca_r[19:12];
        end
    end

    // register device state and outputs
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ckePrev_r   <= 1'b0;
            devState_r  <= DV_POWER_ON;
            mrrRet_r    <= DV_NORMAL;
            devTimer_r  <= 16'h0000;
            initTimer_r <= 16'h0000;
            lastBank_r  <= 2'h0;
            mrWe_r      <= 1'b0;
            mrAddr_r    <= 8'h00;
            mrData_r    <= 8'h00;
        end else begin
            ckePrev_r   <= cke_r;
            devState_r  <= devState_nxt;
            mrrRet_r    <= mrrRet_nxt;
            devTimer_r  <= devTimer_nxt;
            initTimer_r <= initTimer_nxt;
            lastBank_r  <= lastBank_nxt;
            mrWe_r      <= mrWe_nxt;
            mrAddr_r    <= mrAddr_nxt;
            mrData_r    <= mrData_nxt;
        end
    end

    assign devState    = devState_r;
    assign modeRegWe   = mrWe_r;
    assign modeRegAddr = mrAddr_r;
    assign modeRegData = mrData_r;
    // bank states packed three bits each
    generate
        for (g = 0; g < NBANK; g++) begin : gOut
            assign bankStates[3*g +: 3] = bankSt[g];
        end
    endgenerate
endmodule : lpbs_state_logic
`default_nettype wire

/* verification/lpbs_assertions.sv */
// assertion checker for the power and bank state logic
// assumes only the top module ports; states come from registers
`default_nettype none
module lpbs_checker
    import lpbs_pkg::*;
#(
    parameter int TRFCAB = 26,
    parameter int TMRR   = 2,
    parameter int TMRW   = 5
) (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        csPin_n,
    input wire logic        ckePin,
    input wire logic [9:0]  caRise,
    input wire logic [9:0]  caFall,
    input wire lpbs_dev_t   devState,
    input wire logic [11:0] bankStates,
    input wire logic        modeRegWe,
    input wire logic [7:0]  modeRegAddr,
    input wire logic [7:0]  modeRegData
);
    lpbs_dev_t   prev_r, prev_nxt;
    logic [15:0] stay_r, stay_nxt;
    logic [2:0]  bank0;
    assign bank0 = bankStates[2:0];
    // cycles spent so far in the current device state
    always_comb begin
        prev_nxt = devState;
        stay_nxt = (devState == prev_r) ? stay_r + 16'h0001 : 16'h0001;
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prev_r <= DV_POWER_ON;
            stay_r <= 16'h0000;
        end else begin
            prev_r <= prev_nxt;
            stay_r <= stay_nxt;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_act_to_active: assert property (
        $rose(bank0 == BK_ACTIVATING) |->
        (bank0 == BK_ACTIVATING)[*4] ##1 bank0 == BK_ACTIVE)
        else $error("activate time wrong");
    a_pre_to_idle: assert property (
        $rose(bank0 == BK_PRECHARGING) |->
        (bank0 == BK_PRECHARGING)[*4] ##1 bank0 == BK_IDLE)
        else $error("precharge time wrong");
    a_refresh_exit: assert property (
        prev_r == DV_REFRESH && devState != DV_REFRESH |->
        stay_r == TRFCAB && devState == DV_NORMAL)
        else $error("refresh exit wrong");
    a_mrr_exit: assert property (
        prev_r == DV_MR_READ && devState != DV_MR_READ |->
        stay_r == TMRR && devState == DV_NORMAL)
        else $error("mode read exit wrong");
    a_mrw_exit: assert property (
        prev_r == DV_MR_WRITE && devState != DV_MR_WRITE |->
        stay_r == TMRW && devState == DV_NORMAL)
        else $error("mode write exit wrong");
    a_deep_exit: assert property (
        prev_r == DV_DEEP_PD && devState != DV_DEEP_PD |->
        devState == DV_POWER_ON) else $error("deep exit wrong");
    a_pd_exit: assert property (
        prev_r inside {DV_ACT_PD, DV_IDLE_PD, DV_SELF_REF} &&
        devState != prev_r |-> devState == DV_NORMAL)
        else $error("power-down exit wrong");
    a_rst_pd_exit: assert property (
        prev_r == DV_RST_PD && devState != DV_RST_PD |->
        devState inside {DV_RESETTING, DV_NORMAL})
        else $error("resetting power-down exit wrong");
    a_low_cke_hold: assert property (
        (!ckePin)[*5] ##0 devState inside {DV_ACT_PD, DV_IDLE_PD,
        DV_RST_PD, DV_SELF_REF, DV_DEEP_PD} |=> $stable(devState))
        else $error("power state left with clock enable low");
    a_idle_pd_banks: assert property (
        devState inside {DV_IDLE_PD, DV_SELF_REF} |-> bankStates == 12'h000)
        else $error("idle power state with busy bank");
    c_refresh: cover property ($rose(devState == DV_REFRESH));
    c_deep: cover property ($rose(devState == DV_DEEP_PD));
    c_rst_pd: cover property ($rose(devState == DV_RST_PD));
endmodule : lpbs_checker
bind lpbs_state_logic lpbs_checker #(
    .TRFCAB(TRFCAB), .TMRR(TMRR), .TMRW(TMRW)
) u_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .csPin_n(csPin_n),
    .ckePin(ckePin), .caRise(caRise), .caFall(caFall),
    .devState(devState), .bankStates(bankStates), .modeRegWe(modeRegWe),
    .modeRegAddr(modeRegAddr), .modeRegData(modeRegData)
);
`default_nettype wire

/* verification/lpbs_host_model.sv */
// host controller model driving command, chip select, clock enable
// assumes the device samples its pins on rising edges of clk_sys
`default_nettype none
module lpbs_host_model (
    input  wire logic       clk_sys,
    output var  logic       csPin_n,
    output var  logic       ckePin,
    output var  logic [9:0] caRise,
    output var  logic [9:0] caFall
);
    timeunit 1ns;
    timeprecision 1ps;
    // deselected, clock enable low until the bench raises it
    initial begin
        csPin_n = 1'b1;
        ckePin = 1'b0;
        caRise = 10'h3FF;
        caFall = 10'h3FF;
    end
    // one command slot; stale bus inverted once deselected
    task automatic issue(input logic cke, input logic [9:0] r,
                         input logic [9:0] f, input bit rel = 1'b1);
        @(negedge clk_sys);
        ckePin = cke;
        csPin_n = 1'b0;
        caRise = r;
        caFall = f;
        if (rel) begin
            @(negedge clk_sys);
            csPin_n = 1'b1;
            caRise = ~r;
            caFall = ~f;
        end
    endtask : issue
    // nop slots, also the exit wait with the clock running
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            csPin_n = 1'b1;
            caRise = ~caRise;
            caFall = ~caFall;
        end
    endtask : idle
    // clock enable change with chip select high
    task automatic setCke(input logic v);
        @(negedge clk_sys);
        ckePin = v;
        csPin_n = 1'b1;
    endtask : setCke
endmodule : lpbs_host_model
`default_nettype wire

/* verification/lpbs_state_logic_tb.sv */
// self-checking bench for the power and bank state logic
// assumes the host model drives all pins at falling edges
`default_nettype none
`include "lpbs_consts.svh"
module lpbs_state_logic_tb
    import lpbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TRFCAB = `LPBS_CYC(`LPBS_TRFCAB_NS);
    localparam int TMRR   = `LPBS_TMRR_CYC;
    localparam int TMRW   = `LPBS_TMRW_CYC;
    logic        clk_sys, reset_n, csPin_n, ckePin, modeRegWe;
    logic [9:0]  caRise, caFall;
    logic [11:0] bankStates;
    logic [7:0]  modeRegAddr, modeRegData;
    lpbs_dev_t   devState;
    int          err_count, total_checks;
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    lpbs_state_logic #(.TINIT5(20)) uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .csPin_n(csPin_n),
        .ckePin(ckePin), .caRise(caRise), .caFall(caFall),
        .devState(devState), .bankStates(bankStates),
        .modeRegWe(modeRegWe), .modeRegAddr(modeRegAddr),
        .modeRegData(modeRegData));
    lpbs_host_model u_host (.clk_sys(clk_sys), .csPin_n(csPin_n),
        .ckePin(ckePin), .caRise(caRise), .caFall(caFall));
    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string w, input logic [11:0] e, g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    // bank state by index, device state at index 4
    function automatic logic [3:0] obs(input int s);
        return (s < 4) ? {1'b0, bankStates[3*s +: 3]} : devState;
    endfunction : obs
    function automatic logic [9:0] bk(input logic [3:0] c, logic [1:0] b);
        return {1'b0, b, 3'h0, c};
    endfunction : bk
    task automatic waitFor(input int s, input logic [3:0] v);
        int n;
        n = 0;
        while (obs(s) !== v && n < 60) begin
            @(negedge clk_sys);
            n++;
        end
        chk("state", 12'(v), 12'(obs(s)));
        if (n >= 60) end_of_test();
    endtask : waitFor
    // length of a state and the state that follows it
    task automatic dwell(input int s, input logic [3:0] v, input int len,
                         input logic [3:0] nx);
        int n;
        waitFor(s, v);
        n = 0;
        while (obs(s) === v && n < 99) begin
            @(negedge clk_sys);
            n++;
        end
        chk("dwell", 12'(len), 12'(n));
        chk("next state", 12'(nx), 12'(obs(s)));
    endtask : dwell
    task automatic mrw(input logic [7:0] ma, input logic [7:0] op);
        int n;
        n = 0;
        u_host.issue(1'b1, {ma[5:0], `LPBS_CA_MRW}, {op, ma[7:6]}, 1'b0);
        while (modeRegWe !== 1'b1 && n < 10) begin
            u_host.idle(1);
            n++;
        end
        chk("mode write strobe", 12'h001, 12'(modeRegWe));
        chk("mode address", 12'(ma), 12'(modeRegAddr));
        chk("mode data", 12'(op), 12'(modeRegData));
    endtask : mrw
    // power state entry, hold with clock enable low, exit
    task automatic pd(input logic cs, input logic [9:0] r,
                      input logic [3:0] st, input logic [3:0] ex);
        if (cs) u_host.setCke(1'b0);
        else u_host.issue(1'b0, r, 10'h000);
        waitFor(4, st);
        u_host.idle(6);
        chk("held power state", 12'(st), 12'(obs(4)));
        u_host.setCke(1'b1);
        waitFor(4, ex);
        u_host.idle(4);
    endtask : pd
    task automatic t_init();
        chk("reset banks", 12'h000, bankStates);
        chk("reset state", 12'(DV_POWER_ON), 12'(devState));
        u_host.setCke(1'b1);
        u_host.idle(3);
        fork
            mrw(8'h3F, 8'h00);
            waitFor(4, DV_RESETTING);
        join
        fork
            u_host.issue(1'b1, {6'h00, `LPBS_CA_MRR}, 10'h000);
            dwell(4, DV_MR_READ, TMRR, DV_NORMAL);
        join
        $display("test init done");
    endtask : t_init
    // activate code 2, precharge one bank, an idle bank, then all
    task automatic t_bank();
        fork
            u_host.issue(1'b1, bk(4'h2, 2'd1), 10'h000);
            dwell(1, BK_ACTIVATING, 4, BK_ACTIVE);
        join
        fork
            u_host.issue(1'b1, bk(`LPBS_CA_PRE, 2'd1), 10'h000);
            dwell(1, BK_PRECHARGING, 4, BK_IDLE);
        join
        fork
            u_host.issue(1'b1, bk(`LPBS_CA_PRE, 2'd2), 10'h000);
            dwell(2, BK_PRECHARGING, 4, BK_IDLE);
        join
        u_host.issue(1'b1, bk(4'h2, 2'd0), 10'h000);
        u_host.issue(1'b1, bk(4'h2, 2'd3), 10'h000);
        waitFor(3, BK_ACTIVE);
        fork
            u_host.issue(1'b1, bk(`LPBS_CA_PRE, 2'd0) | 10'h010, 10'h000);
            dwell(3, BK_PRECHARGING, 4, BK_IDLE);
        join
        chk("all idle", 12'h000, bankStates);
        $display("test bank done");
    endtask : t_bank
    task automatic t_burst();
        fork
            u_host.issue(1'b1, bk(4'h2, 2'd0), 10'h000);
            waitFor(0, BK_ACTIVE);
        join
        fork
            begin
                u_host.issue(1'b1, bk(`LPBS_CA_RD, 2'd0), 10'h000);
                u_host.issue(1'b1, bk(`LPBS_CA_RD, 2'd0), 10'h000);
            end
            dwell(0, BK_READING, 6, BK_ACTIVE);
        join
        fork
            begin
                u_host.issue(1'b1, bk(`LPBS_CA_WR, 2'd0), 10'h000, 1'b0);
                u_host.issue(1'b1, {6'h00, `LPBS_CA_BST}, 10'h000);
            end
            dwell(0, BK_WRITING, 1, BK_ACTIVE);
        join
        fork
            u_host.issue(1'b1, bk(`LPBS_CA_RD, 2'd0), 10'h001);
            dwell(0, BK_READING, 4, BK_PRECHARGING);
        join
        dwell(0, BK_PRECHARGING, 4, BK_IDLE);
        $display("test burst done");
    endtask : t_burst
    task automatic t_mode();
        fork
            mrw(8'h05, 8'hA5);
            dwell(4, DV_MR_WRITE, TMRW, DV_NORMAL);
        join
        fork
            u_host.issue(1'b1, {6'h00, `LPBS_CA_REFAB}, 10'h000);
            dwell(4, DV_REFRESH, TRFCAB, DV_NORMAL);
        join
        u_host.issue(1'b1, {6'h00, `LPBS_CA_REFPB}, 10'h000);
        u_host.idle(8);
        chk("per-bank refresh", 12'(DV_NORMAL), 12'(devState));
        $display("test mode done");
    endtask : t_mode
    task automatic t_power();
        fork
            u_host.issue(1'b1, bk(4'h2, 2'd3), 10'h000);
            waitFor(3, BK_ACTIVE);
        join
        pd(1'b1, 10'h000, DV_ACT_PD, DV_NORMAL);
        fork
            u_host.issue(1'b1, bk(`LPBS_CA_PRE, 2'd3), 10'h000);
            waitFor(3, BK_IDLE);
        join
        pd(1'b1, 10'h000, DV_IDLE_PD, DV_NORMAL);
        pd(1'b0, {6'h00, `LPBS_CA_REFPB}, DV_SELF_REF, DV_NORMAL);
        pd(1'b0, {6'h00, `LPBS_CA_BST}, DV_DEEP_PD, DV_POWER_ON);
        fork
            mrw(8'h3F, 8'h00);
            waitFor(4, DV_RESETTING);
        join
        pd(1'b1, 10'h000, DV_RST_PD, DV_RESETTING);
        waitFor(4, DV_NORMAL);
        // reset from idle, then leave power-down once the init time is over
        fork
            mrw(8'h3F, 8'h00);
            waitFor(4, DV_RESETTING);
        join
        u_host.setCke(1'b0);
        waitFor(4, DV_RST_PD);
        u_host.idle(24);
        u_host.setCke(1'b1);
        u_host.idle(3);
        chk("reset power-down exit", 12'(DV_NORMAL), 12'(devState));
        $display("test power done");
    endtask : t_power
    initial begin
        reset_n = 1'b0;
        err_count = 0;
        total_checks = 0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        reset_n = 1'b1;
        t_init();
        t_bank();
        t_burst();
        t_mode();
        t_power();
        end_of_test();
    end
endmodule : lpbs_state_logic_tb
`default_nettype wire
